// ==== src/cfg_access_map.svh ====
// Purpose: Offsets, keys, field positions and reset values of the I/O decode block
// Assumes: Byte-wide I/O port cycles with a 16-bit address
// Notes:   Definitions only
`ifndef CFG_ACCESS_MAP_SVH
`define CFG_ACCESS_MAP_SVH

// Runtime block register offsets
`define RT_OFS_WAKE_STATUS   2'h0
`define RT_OFS_WAKE_ENABLE   2'h1
`define RT_OFS_GPIO_DATA     2'h2
`define RT_OFS_RESERVED      2'h3
`define RT_RESET_VAL         8'h00
`define RT_BASE_MIN          12'h100
`define RT_FLAG_BIT          0
`define RT_GPIO_LSB          4

// Configuration access keys
`define CFG_KEY_ENTER        8'h55
`define CFG_KEY_EXIT         8'haa
`define CFG_INDEX_MAX        8'h39
`define CFG_NUM_REGS         58

// Configuration register indices
`define CFG_IDX_BASE_LOW     6'h12
`define CFG_IDX_BASE_HIGH    6'h13
`define CFG_IDX_RT_UPPER     6'h2f
`define CFG_IDX_RT_LOWER     6'h30

// Configuration port base chosen by the strap
`define CFG_BASE_STRAP0      8'h2e
`define CFG_BASE_STRAP1      8'h4e
`define CFG_BASE_HIGH_RST    8'h00

`endif

// ==== src/cfg_access_pkg.sv ====
// Purpose: Types shared by both ends of the I/O port link
// Assumes: Constants live in cfg_access_map.svh
// Notes:   Types only
package cfg_access_pkg;
    typedef logic [15:0] io_addr_t;
    typedef logic [7:0]  io_byte_t;
    typedef enum logic {run_state, config_state} cfg_state_e;
endpackage : cfg_access_pkg

// ==== src/io_port_if.sv ====
// Purpose: Host I/O port cycle link between host controller and device
// Assumes: One clock, read data stand one cycle after the read strobe
// Notes:   No clocking block; the bench joins both ends here
`timescale 1ns/1ps
interface io_port_if;
    cfg_access_pkg::io_addr_t io_addr;   // Port address
    cfg_access_pkg::io_byte_t io_wdata;  // Write data
    logic                     io_wr;     // Write strobe
    logic                     io_rd;     // Read strobe
    cfg_access_pkg::io_byte_t io_rdata;  // Read data
    logic                     io_rvalid; // Device claimed the read

    modport host   (output io_addr, io_wdata, io_wr, io_rd, input io_rdata, io_rvalid);
    modport device (input io_addr, io_wdata, io_wr, io_rd, output io_rdata, io_rvalid);
endinterface : io_port_if

// ==== src/io_decode_device.sv ====
// Purpose: Device end: key-driven configuration access ports and runtime wake/GPIO block
// Assumes: rstn is the standby-supply power-on reset; host_reset_n is the hard reset pin
// Notes:   Configuration register contents are plain storage here
//
// Function
// - Runtime decode: bits 11:2 match, 15:12 zero
// - Runtime base 0x0100-0x0FFC, four registers
// - Runtime base below 0x100 disables decode
// - Reserved bits read zero, writes ignored
// - Ring falling edge sets flag, drives wake
// - Write one clears flag; zero keeps
// - Wake registers reset only on standby power-on
// - Wake enable bit gates wake output
// - GPIO data bits 7:4, standby reset
// - Strap latched at hard reset picks base
// - Base follows programmed base registers
// - Index/data ports only in configuration state
// - Index readable only in configuration state
// - Start in run state after power-up
// - Key 55h enters configuration state
// - Index selects register for data port
// - Configuration state persists until exit key or hard reset
// - Key AAh exits configuration state
// - Functions keep running in configuration state
// - Host enters, programs, then exits
// - Hard reset leaves wake registers alone
// - Index register only in configuration state
`timescale 1ns/1ps
`include "cfg_access_map.svh"
module io_decode_device (
    input  wire logic   mclk,              // 125 MHz clock
    input  wire logic   rstn,              // Standby power-on reset, active low
    io_port_if.device   bus,               // Host port cycles
    input  wire logic   host_reset_n,      // Hard reset pin, active low
    input  wire logic   base_select_strap, // Strap pin, caught at hard reset
    input  wire logic   ring_indicate_n,   // Ring indicate pin, active low
    output logic        wake_out_n,        // Wake output, active low
    output logic [3:0]  host_gpio_out,     // Host GPIO 7..4 data
    output logic        cfg_active         // High in configuration state
);
    // Pin synchronisers: stage one is read by stage two only
    logic [1:0] hrst_sync_reg;
    logic [1:0] strap_sync_reg;
    logic [2:0] ring_sync_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hrst_sync_reg  <= 2'h3;
            strap_sync_reg <= 2'h0;
            ring_sync_reg  <= 3'h7;
        end else begin
            hrst_sync_reg  <= {hrst_sync_reg[0], host_reset_n};
            strap_sync_reg <= {strap_sync_reg[0], base_select_strap};
            ring_sync_reg  <= {ring_sync_reg[1:0], ring_indicate_n};
        end
    end

    // Delayed hard reset level for edge detection
    logic hrst_prev_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) hrst_prev_reg <= 1'b1;
        else       hrst_prev_reg <= hrst_sync_reg[1];
    end

    logic hard_fall;
    logic hard_active;
    logic ring_fall;
    assign hard_fall   = hrst_prev_reg & ~hrst_sync_reg[1];
    assign hard_active = ~hrst_sync_reg[1];
    assign ring_fall   = ring_sync_reg[2] & ~ring_sync_reg[1];

    // Configuration registers; index 12h/13h form the port base
    logic [7:0] cfg_mem [`CFG_NUM_REGS];
    logic [7:0] index_select_reg;
    cfg_access_pkg::cfg_state_e state_reg;

    logic [15:0] cfg_base;
    logic [11:0] rt_base;
    logic        cfg_hit_key;
    logic        cfg_hit_data;
    logic        rt_en;
    logic        rt_hit;
    logic [1:0]  rt_ofs;
    logic        in_cfg;
    logic        idx_ok;

    assign cfg_base     = {cfg_mem[`CFG_IDX_BASE_HIGH], cfg_mem[`CFG_IDX_BASE_LOW]};
    assign cfg_hit_key  = (bus.io_addr == cfg_base);
    assign cfg_hit_data = (bus.io_addr == cfg_base + 16'h0001);
    assign in_cfg       = (state_reg == cfg_access_pkg::config_state);
    assign idx_ok       = (index_select_reg <= `CFG_INDEX_MAX);
    // Upper holds address bits 11:8, lower bits 7:2 of the runtime base
    assign rt_base = {cfg_mem[`CFG_IDX_RT_UPPER][3:0], cfg_mem[`CFG_IDX_RT_LOWER][7:2], 2'h0};
    assign rt_en   = (rt_base >= `RT_BASE_MIN);
    assign rt_hit  = rt_en && (bus.io_addr[15:12] == 4'h0)
                     && (bus.io_addr[11:2] == rt_base[11:2]);
    assign rt_ofs  = bus.io_addr[1:0];

    // Run/configuration state; power-up and hard reset both land in run
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= cfg_access_pkg::run_state;
        end else if (hard_active) begin
            state_reg <= cfg_access_pkg::run_state;
        end else if (bus.io_wr && cfg_hit_key) begin
            unique case (state_reg)
                cfg_access_pkg::run_state: begin
                    if (bus.io_wdata == `CFG_KEY_ENTER)
                        state_reg <= cfg_access_pkg::config_state;
                end
                cfg_access_pkg::config_state: begin
                    if (bus.io_wdata == `CFG_KEY_EXIT)
                        state_reg <= cfg_access_pkg::run_state;
                end
            endcase
        end
    end

    // Index select register: written at the key address while configured
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            index_select_reg <= 8'h00;
        end else if (bus.io_wr && cfg_hit_key && in_cfg
                     && bus.io_wdata != `CFG_KEY_EXIT) begin
            index_select_reg <= bus.io_wdata;
        end
    end

    // Strap caught on the falling edge of hard reset; only the base bytes reload
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `CFG_NUM_REGS; i++) cfg_mem[i] <= 8'h00;
            cfg_mem[`CFG_IDX_BASE_LOW] <= `CFG_BASE_STRAP0;
        end else if (hard_fall) begin
            cfg_mem[`CFG_IDX_BASE_LOW]  <= strap_sync_reg[1] ? `CFG_BASE_STRAP1
                                                             : `CFG_BASE_STRAP0;
            cfg_mem[`CFG_IDX_BASE_HIGH] <= `CFG_BASE_HIGH_RST;
        end else if (bus.io_wr && cfg_hit_data && in_cfg && idx_ok) begin
            cfg_mem[index_select_reg[5:0]] <= bus.io_wdata;
        end
    end

    // Runtime writes; standby reset only, hard reset has no say here
    logic rt_wr;
    assign rt_wr = bus.io_wr && rt_hit;
    logic flag_reg;
    logic enable_reg;
    logic [3:0] gpio_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flag_reg <= 1'b0;
        end else if (ring_fall) begin
            flag_reg <= 1'b1;   // Set beats a simultaneous clear
        end else if (rt_wr && rt_ofs == `RT_OFS_WAKE_STATUS
                     && bus.io_wdata[`RT_FLAG_BIT]) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            enable_reg <= 1'b0;
            gpio_reg   <= 4'h0;
        end else if (rt_wr) begin
            if (rt_ofs == `RT_OFS_WAKE_ENABLE) enable_reg <= bus.io_wdata[`RT_FLAG_BIT];
            if (rt_ofs == `RT_OFS_GPIO_DATA)   gpio_reg <= bus.io_wdata[7:`RT_GPIO_LSB];
        end
    end

    // Wake output and GPIO pins come from flops; not gated by config state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wake_out_n    <= 1'b1;
            host_gpio_out <= 4'h0;
            cfg_active    <= 1'b0;
        end else begin
            wake_out_n    <= ~(flag_reg & enable_reg);
            host_gpio_out <= gpio_reg;
            cfg_active    <= in_cfg;
        end
    end

    // Read mux: the one cycle delay is the registered answer
    function automatic logic [7:0] rt_read(input logic [1:0] ofs);
        unique case (ofs)
            `RT_OFS_WAKE_STATUS: rt_read = {7'h00, flag_reg};
            `RT_OFS_WAKE_ENABLE: rt_read = {7'h00, enable_reg};
            `RT_OFS_GPIO_DATA:   rt_read = {gpio_reg, 4'h0};
            `RT_OFS_RESERVED:    rt_read = `RT_RESET_VAL;
        endcase
    endfunction : rt_read

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bus.io_rdata  <= 8'h00;
            bus.io_rvalid <= 1'b0;
        end else if (bus.io_rd && rt_hit) begin
            bus.io_rdata  <= rt_read(rt_ofs);
            bus.io_rvalid <= 1'b1;
        end else if (bus.io_rd && in_cfg && cfg_hit_key) begin
            bus.io_rdata  <= index_select_reg;
            bus.io_rvalid <= 1'b1;
        end else if (bus.io_rd && in_cfg && cfg_hit_data) begin
            bus.io_rdata  <= idx_ok ? cfg_mem[index_select_reg[5:0]] : 8'h00;
            bus.io_rvalid <= 1'b1;
        end else begin
            bus.io_rdata  <= 8'h00;
            bus.io_rvalid <= 1'b0;
        end
    end
endmodule : io_decode_device

// ==== src/io_host_ctrl.sv ====
// Purpose: Host end: turns software port orders into I/O port cycles
// Assumes: Software sequences keys, index and data writes itself
// Notes:   One cycle in, one cycle out; no queue
`timescale 1ns/1ps
`include "cfg_access_map.svh"
module io_host_ctrl (
    input  wire logic        mclk,       // 125 MHz clock
    input  wire logic        rstn,       // Reset, active low
    io_port_if.host          bus,        // Port cycles to device
    input  wire logic [15:0] cmd_addr,   // Port address
    input  wire logic [7:0]  cmd_wdata,  // Write data
    input  wire logic        cmd_wr,     // Write strobe
    input  wire logic        cmd_rd,     // Read strobe
    output logic      [7:0]  cmd_rdata,  // Read data
    output logic             cmd_rvalid  // Device answered the read
);
    // Issue stage; keys 55h/aah and index/data bytes pass as given so
    // software keeps the enter, program, exit order itself
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bus.io_addr  <= 16'h0000;
            bus.io_wdata <= 8'h00;
            bus.io_wr    <= 1'b0;
            bus.io_rd    <= 1'b0;
        end else begin
            bus.io_addr  <= cmd_addr;
            bus.io_wdata <= cmd_wdata;
            bus.io_wr    <= cmd_wr;
            bus.io_rd    <= cmd_rd & ~cmd_wr;
        end
    end

    // Answer stage; an unclaimed read returns zero with valid low
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmd_rdata  <= 8'h00;
            cmd_rvalid <= 1'b0;
        end else begin
            cmd_rdata  <= bus.io_rdata;
            cmd_rvalid <= bus.io_rvalid;
        end
    end
endmodule : io_host_ctrl

// ==== tb/io_link_monitor.sv ====
// Purpose: Concurrent checks on the host port link and device status pins
// Assumes: Config base 0x002e, runtime block placed at 0x0240 by the bench
// Notes:   Instantiated beside the interface in tb
`timescale 1ns/1ps
module io_link_monitor (
    input wire logic                     mclk,       // Clock
    input wire logic                     rstn,       // Reset, active low
    input wire cfg_access_pkg::io_addr_t io_addr,    // Port address
    input wire cfg_access_pkg::io_byte_t io_wdata,   // Write data
    input wire logic                     io_wr,      // Write strobe
    input wire logic                     io_rd,      // Read strobe
    input wire cfg_access_pkg::io_byte_t io_rdata,   // Read data
    input wire logic                     io_rvalid,  // Read claimed
    input wire logic                     cfg_active, // Configuration state
    input wire logic                     wake_out_n  // Wake pin, active low
);
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Answers only follow a read strobe, and idle data is zero
    property p_rd_cause; io_rvalid |-> $past(io_rd); endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("answer without read");
    property p_rdata_idle; !io_rvalid |-> io_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("idle read data");
    // Key writes move the state within the flop lag
    property p_enter;
        io_wr && io_addr == 16'h002e && io_wdata == 8'h55 |-> ##[1:2] cfg_active;
    endproperty
    a_enter: assert property (p_enter) else $error("entry key ignored");
    property p_exit;
        io_wr && io_addr == 16'h002e && io_wdata == 8'haa && cfg_active |-> ##[1:2] !cfg_active;
    endproperty
    a_exit: assert property (p_exit) else $error("exit key ignored");
    // Entry write one cycle earlier would not show on cfg_active yet, so it is excluded
    property p_idx_shut;
        io_rd && io_addr == 16'h002e && !cfg_active && !$past(io_wr) |=> !io_rvalid;
    endproperty
    a_idx_shut: assert property (p_idx_shut) else $error("index read in run state");
    property p_high_addr; io_rd && io_addr[15:12] != 4'h0 |=> !io_rvalid; endproperty
    a_high_addr: assert property (p_high_addr) else $error("upper address claimed");
    property p_rsvd_zero; io_rd && io_addr == 16'h0243 |=> io_rdata == 8'h00; endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved not zero");
    property p_wake_clr;
        io_wr && io_addr == 16'h0240 && io_wdata[0] |-> ##[1:3] wake_out_n;
    endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("wake not released");
    c_enter: cover property (io_wr && io_wdata == 8'h55);
    c_wake: cover property ($fell(wake_out_n));
    c_read: cover property (io_rvalid);
endmodule : io_link_monitor

// ==== tb/tb.sv ====
// Purpose: Both ends joined, driven from the host command port against a model
// Assumes: Host command read answers three cycles after the strobe
// Notes:   Model keeps config storage, state, index and runtime registers
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0;
    logic rstn, host_reset_n, base_select_strap, ring_indicate_n, cmd_wr, cmd_rd;
    logic [15:0] cmd_addr;
    logic [7:0] cmd_wdata, cmd_rdata;
    logic cmd_rvalid, wake_out_n, cfg_active;
    logic [3:0] host_gpio_out;
    int n_fail, n_tests, cfgm[64], rt[4], idx, i, a, d;
    bit cst;
    // Free running clock
    always #4 mclk = ~mclk;
    io_port_if io_port_if_inst ();
    io_host_ctrl io_host_ctrl_inst (.mclk(mclk), .rstn(rstn), .bus(io_port_if_inst.host),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));
    io_decode_device io_decode_device_inst (.mclk(mclk), .rstn(rstn),
        .bus(io_port_if_inst.device), .host_reset_n(host_reset_n),
        .base_select_strap(base_select_strap), .ring_indicate_n(ring_indicate_n),
        .wake_out_n(wake_out_n), .host_gpio_out(host_gpio_out), .cfg_active(cfg_active));
    io_link_monitor io_link_monitor_inst (.mclk(mclk), .rstn(rstn),
        .io_addr(io_port_if_inst.io_addr), .io_wdata(io_port_if_inst.io_wdata),
        .io_wr(io_port_if_inst.io_wr), .io_rd(io_port_if_inst.io_rd),
        .io_rdata(io_port_if_inst.io_rdata), .io_rvalid(io_port_if_inst.io_rvalid),
        .cfg_active(cfg_active), .wake_out_n(wake_out_n));
    function automatic int base(); return cfgm[8'h13] * 256 + cfgm[8'h12]; endfunction : base
    function automatic int rtb();
        return (cfgm[8'h2f] % 16) * 256 + (cfgm[8'h30] / 4) * 4;
    endfunction : rtb
    // Expected answer, -1 when nothing should claim the read
    function automatic int expv(input int a);
        if (a == base()) return cst ? idx : -1;
        if (a == base() + 1) return !cst ? -1 : (idx <= 8'h39 ? cfgm[idx] : 0);
        if (rtb() >= 16'h100 && a / 4 == rtb() / 4) return rt[a % 4];
        return -1;
    endfunction : expv
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input int a, input int d);
        @(posedge mclk);
        cmd_addr <= a[15:0];
        cmd_wdata <= d[7:0];
        cmd_wr <= 1'b1;
        @(posedge mclk);
        cmd_wr <= 1'b0;
        if (a == base()) begin
            if (!cst) cst = (d == 8'h55);
            else if (d == 8'haa) cst = 0;
            else idx = d;
        end else if (a == base() + 1) begin
            if (cst && idx <= 8'h39) cfgm[idx] = d;
        end else if (rtb() >= 16'h100 && a / 4 == rtb() / 4) begin
            if (a % 4 == 0 && d % 2 == 1) rt[0] = 0;
            if (a % 4 == 1) rt[1] = d % 2;
            if (a % 4 == 2) rt[2] = d & 8'hf0;
        end
    endtask : wr
    // The answer stands only in the third cycle after the strobe; sampled on the
    // falling edge there, then checked to drop so a wrong latency cannot slip by
    task automatic rd(input int a);
        int e;
        e = expv(a);
        @(posedge mclk);
        cmd_addr <= a[15:0];
        cmd_rd <= 1'b1;
        @(posedge mclk);
        cmd_rd <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("rvalid", {7'h0, e >= 0}, {7'h0, cmd_rvalid});
        if (e >= 0) chk("rdata", e[7:0], cmd_rdata);
        @(negedge mclk);
        chk("rvalid_len", 8'h00, {7'h0, cmd_rvalid});
    endtask : rd
    task automatic pins();
        chk("wake_out_n", {7'h0, !(rt[0] && rt[1])}, {7'h0, wake_out_n});
        chk("gpio", 8'(rt[2] / 16), {4'h0, host_gpio_out});
        chk("cfg_active", {7'h0, cst}, {7'h0, cfg_active});
    endtask : pins
    task automatic ring();
        @(posedge mclk);
        ring_indicate_n <= 1'b0;
        repeat (4) @(posedge mclk);
        ring_indicate_n <= 1'b1;
        repeat (6) @(posedge mclk);
        rt[0] = 1;
    endtask : ring
    // Strap is settled well before the hard reset falls
    task automatic hreset(input bit s);
        @(posedge mclk);
        base_select_strap <= s;
        repeat (4) @(posedge mclk);
        host_reset_n <= 1'b0;
        repeat (6) @(posedge mclk);
        host_reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        cst = 0;
        cfgm[8'h12] = s ? 8'h4e : 8'h2e;
        cfgm[8'h13] = 0;
    endtask : hreset
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        #400000;
        n_fail++;
        stop_test();
    end
    // Main sequence
    initial begin
        {rstn, cmd_wr, cmd_rd, base_select_strap, cmd_addr, cmd_wdata} = '0;
        {host_reset_n, ring_indicate_n} = 2'b11;
        foreach (cfgm[k]) cfgm[k] = 0;
        cfgm[8'h12] = 8'h2e;
        void'($urandom(32'h8118));
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        pins();
        rd(16'h002e);
        rd(16'h002f);
        wr(16'h002e, 8'h12); wr(16'h002e, 8'haa); rd(16'h002e);
        wr(16'h002e, 8'h55); wr(16'h002e, 8'h12); rd(16'h002e); rd(16'h002f);
        wr(16'h002e, 8'h2f); wr(16'h002f, 8'h02); wr(16'h002e, 8'h30); wr(16'h002f, 8'h40);
        rd(16'h002f);
        for (i = 0; i < 8; i++) begin
            a = $urandom % 58;
            if (a inside {8'h12, 8'h13, 8'h2f, 8'h30}) a = 1;
            d = $urandom % 256;
            wr(16'h002e, a); wr(16'h002f, d); rd(16'h002e); rd(16'h002f);
        end
        wr(16'h002e, 8'h3a); rd(16'h002f);
        wr(16'h0242, 8'hff); wr(16'h0241, 8'hff);
        for (a = 16'h0240; a < 16'h0244; a++) rd(a);
        rd(16'h1240); pins();
        wr(16'h002e, 8'haa); rd(16'h002f); pins();
        ring(); rd(16'h0240); pins();
        wr(16'h0240, 8'hfe); rd(16'h0240); pins();
        wr(16'h0240, 8'h01); rd(16'h0240); pins();
        wr(16'h0241, 8'h00); ring(); rd(16'h0240); pins();
        hreset(1'b1); rd(16'h0240); rd(16'h0241); pins();
        wr(16'h004e, 8'h55); wr(16'h004e, 8'h12); rd(16'h004f);
        wr(16'h004f, 8'h60); wr(16'h0060, 8'haa); rd(16'h0061); pins();
        hreset(1'b0); wr(16'h002e, 8'h55); wr(16'h002e, 8'h30); wr(16'h002f, 8'hf0);
        wr(16'h002e, 8'h2f); wr(16'h002f, 8'h00); rd(16'h00f0); rd(16'h00f2);
        wr(16'h002e, 8'haa); rd(16'h002e);
        // Standby reset in mid-run: wake, GPIO and configuration storage go back to defaults
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        foreach (cfgm[k]) cfgm[k] = 0;
        foreach (rt[k]) rt[k] = 0;
        cfgm[8'h12] = 8'h2e;
        cst = 0;
        idx = 0;
        @(negedge mclk);
        pins();
        wr(16'h002e, 8'h55); wr(16'h002e, 8'h2f); rd(16'h002f); pins();
        wr(16'h002e, 8'haa); rd(16'h002e);
        stop_test();
    end
endmodule : tb
